// ### dsl_pkg.sv
// Shared constants, encodings and carrier types for the serial DAC load control.
package dsl_pkg;
	localparam int           DSL_WORD_W   = 24;
	localparam int           DSL_CODE_W   = 16;
	localparam int           DSL_CODE_MSB = DSL_CODE_W - 1;
	localparam int           DSL_RD_BIT   = 23;
	localparam int           DSL_SEL_HI   = 22;
	localparam int           DSL_SEL_LO   = 20;
	localparam int           DSL_FMT_BIT  = 0;
	localparam int           DSL_FIFO_DEP = 16;
	localparam logic [4:0]   DSL_CNT_FULL = 5'h18;
	localparam logic [4:0]   DSL_CNT_MAX  = 5'h1F;
	localparam logic [15:0]  DSL_CODE_RST = 16'h0000;
	localparam logic [15:0]  DSL_PRESET_RST = 16'h0000;
	localparam logic         DSL_FMT_RST  = 1'h0;

	// Target selector carried in a command word.
	typedef enum logic [2:0] {
		DSL_SEL_NOP    = 3'h0,
		DSL_SEL_CODE   = 3'h1,
		DSL_SEL_CTRL   = 3'h2,
		DSL_SEL_PRESET = 3'h3
	} dsl_sel_t;

	// One received frame and the load strobe level seen at its end.
	typedef struct packed {
		logic                  hold;
		logic [DSL_WORD_W-1:0] word;
	} dsl_entry_t;

	// Pin levels after synchronisation.
	typedef struct packed {
		logic sclk;
		logic frame_n;
		logic sdi;
		logic strobe_n;
		logic clear_n;
		logic reset_n;
	} dsl_pins_t;

	localparam dsl_pins_t DSL_PINS_IDLE = '{sclk: 1'h0, frame_n: 1'h1, sdi: 1'h0,
		strobe_n: 1'h0, clear_n: 1'h1, reset_n: 1'h1};
endpackage

// ### dsl_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides and a flush.
module dsl_fifo
	import dsl_pkg::*;
#(
	parameter int W     = 25,
	parameter int DEPTH = 16
) (
	input  wire logic         sys_clk,
	input  wire logic         srst,
	input  wire logic         flush,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW:0]             wp;
		logic [AW:0]             rp;
	} dsl_fifo_st_t;

	dsl_fifo_st_t st_ff;
	dsl_fifo_st_t nxt_st;

	assign out_valid = st_ff.wp != st_ff.rp;
	assign in_ready  = (st_ff.wp[AW] == st_ff.rp[AW]) || (st_ff.wp[AW-1:0] != st_ff.rp[AW-1:0]);
	assign out_data  = st_ff.mem[st_ff.rp[AW-1:0]];

	always_comb begin
		nxt_st = st_ff;
		if (in_valid && in_ready) begin
			nxt_st.mem[st_ff.wp[AW-1:0]] = in_data;
			nxt_st.wp = st_ff.wp + 1'b1;
		end
		if (out_valid && out_ready) begin
			nxt_st.rp = st_ff.rp + 1'b1;
		end
		if (srst || flush) begin
			nxt_st.wp = '0;
			nxt_st.rp = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		st_ff <= nxt_st;
	end
endmodule

// ### dsl_top.sv
// Serial load control: frame receiver, word FIFO, register update and readback.
// Notes on behaviour
// RULE1: Reset pin low returns code, clear code, format and all digital state to power-on.
// RULE2: Clear pin low loads output code from the clear code and updates the level.
// RULE3: Output level follows the current format, straight binary or two's complement.
// RULE4: Strobe low at frame end updates the output code with the new word.
// RULE5: Strobe high at frame end fills only the holding register; falling strobe loads it.
// RULE6: The host always drives the load strobe to a defined level.
// RULE7: Readback output changes only on rising serial clock edges.
// RULE8: A 24-bit shift register takes one input bit per falling serial clock edge.
// RULE9: Host keeps write serial clock at or below 35 MHz.
// RULE10: Low frame select enables shifting; clock edges are ignored while it is high.
// RULE11: The received word acts on its target at frame end, never while shifting; words queued while clear is low act when it rises, even mid-frame.
// RULE12: Host keeps readback serial clock at or below 16 MHz.
// RULE13: Host gives exactly 24 falling edges per frame; other counts are discarded.
module dsl_top
	import dsl_pkg::*;
#(
	parameter int FIFO_DEPTH = DSL_FIFO_DEP
) (
	input  wire logic                  sys_clk,
	input  wire logic                  srst,
	input  wire logic                  sclk,
	input  wire logic                  frame_sel_n,
	input  wire logic                  serial_write_in,
	input  wire logic                  load_output_strobe_n,
	input  wire logic                  clear_to_preset_n,
	input  wire logic                  dev_reset_n,
	output logic                       serial_readback_out,
	output logic                       serial_readback_oe,
	output logic [DSL_CODE_W-1:0]      dac_code,
	output logic [DSL_CODE_W-1:0]      dac_level,
	output logic                       twos_comp_sel,
	output logic                       frame_overrun
);
	typedef struct packed {
		dsl_pins_t             s1;
		dsl_pins_t             s2;
		dsl_pins_t             s3;
		logic [DSL_WORD_W-1:0] shreg;
		logic [4:0]            cnt;
		logic [DSL_CODE_W-1:0] hold_reg;
		logic [DSL_CODE_W-1:0] code;
		logic [DSL_CODE_W-1:0] preset_code;
		logic                  fmt;
		logic [2:0]            rb_sel;
		logic [DSL_WORD_W-1:0] rb_sh;
		logic                  rb_arm;
		logic                  rb_live;
		logic                  rb_bit;
		logic                  rb_oe;
		logic [DSL_CODE_W-1:0] level;
		logic                  overrun;
	} dsl_state_t;

	dsl_state_t st_ff;
	dsl_state_t nxt_st;
	dsl_pins_t  pins;
	dsl_entry_t push_e;
	dsl_entry_t pop_e;
	dsl_sel_t   pop_sel;
	logic       sclk_fall;
	logic       sclk_rise;
	logic       frame_start;
	logic       frame_end;
	logic       strobe_fall;
	logic       push_valid;
	logic       push_ready;
	logic       pop_valid;
	logic       pop_ready;
	logic       pop;
	logic       fifo_flush;
	logic [DSL_CODE_W-1:0] rb_val;

	assign pins = '{sclk: sclk, frame_n: frame_sel_n, sdi: serial_write_in,
		strobe_n: load_output_strobe_n, clear_n: clear_to_preset_n, reset_n: dev_reset_n};

	// Edges come from the second and third stages; an 80 ns link clock leaves many samples.
	assign sclk_fall   = st_ff.s3.sclk & ~st_ff.s2.sclk; // [RULE9] [RULE12]
	assign sclk_rise   = ~st_ff.s3.sclk & st_ff.s2.sclk;
	assign frame_start = st_ff.s3.frame_n & ~st_ff.s2.frame_n;
	assign frame_end   = ~st_ff.s3.frame_n & st_ff.s2.frame_n;
	// A floating strobe would give spurious loads; the host drives it. [RULE6]
	assign strobe_fall = st_ff.s3.strobe_n & ~st_ff.s2.strobe_n;

	// Only complete words enter the FIFO; a full FIFO drops the word and flags it.
	assign push_valid = frame_end && (st_ff.cnt == DSL_CNT_FULL) && st_ff.s2.reset_n; // [RULE13]
	assign push_e     = '{hold: st_ff.s2.strobe_n, word: st_ff.shreg};
	// Clear or reset holds the drain side; under clear words wait instead of racing the preset, while reset flushes them.
	assign pop_ready  = st_ff.s2.clear_n && st_ff.s2.reset_n;
	assign fifo_flush = !st_ff.s2.reset_n;
	assign pop        = pop_valid && pop_ready;
	assign pop_sel    = dsl_sel_t'(pop_e.word[DSL_SEL_HI:DSL_SEL_LO]);

	dsl_fifo #(
		.W     ($bits(dsl_entry_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.flush     (fifo_flush),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_e),
		.out_valid (pop_valid),
		.out_ready (pop_ready),
		.out_data  (pop_e)
	);

	always_comb begin
		rb_val = '0;
		unique case (dsl_sel_t'(st_ff.rb_sel))
			DSL_SEL_CODE: rb_val = st_ff.code;
			DSL_SEL_CTRL: rb_val[DSL_FMT_BIT] = st_ff.fmt;
			DSL_SEL_PRESET: rb_val = st_ff.preset_code;
			default:      rb_val = st_ff.hold_reg;
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = pins;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		if (frame_start) begin
			nxt_st.cnt = '0;
			nxt_st.rb_live = st_ff.rb_arm;
			nxt_st.rb_arm = 1'b0;
			nxt_st.rb_sh = {st_ff.rb_sel, 1'b0, 4'h0, rb_val};
		end else if (!st_ff.s2.frame_n && sclk_fall) begin // [RULE10]
			nxt_st.shreg = {st_ff.shreg[DSL_WORD_W-2:0], st_ff.s2.sdi}; // [RULE8]
			if (st_ff.cnt != DSL_CNT_MAX) begin
				nxt_st.cnt = st_ff.cnt + 5'h01;
			end
		end
		if (!st_ff.s2.frame_n && sclk_rise && st_ff.rb_live) begin
			nxt_st.rb_bit = st_ff.rb_sh[DSL_WORD_W-1]; // [RULE7]
			nxt_st.rb_sh = {st_ff.rb_sh[DSL_WORD_W-2:0], 1'b0};
		end
		if (frame_end) begin
			nxt_st.rb_live = 1'b0;
			if (push_valid && !push_ready) begin
				nxt_st.overrun = 1'b1;
			end
		end
		if (strobe_fall) begin
			nxt_st.code = st_ff.hold_reg; // [RULE5]
		end
		// Words take effect only when drained after the frame has closed. [RULE11]
		if (pop) begin
			if (pop_e.word[DSL_RD_BIT]) begin
				nxt_st.rb_sel = pop_e.word[DSL_SEL_HI:DSL_SEL_LO];
				nxt_st.rb_arm = 1'b1;
			end else begin
				unique case (pop_sel)
					DSL_SEL_CODE: begin
						nxt_st.hold_reg = pop_e.word[DSL_CODE_MSB:0];
						if (!pop_e.hold) begin
							nxt_st.code = pop_e.word[DSL_CODE_MSB:0]; // [RULE4]
						end
					end
					DSL_SEL_CTRL: nxt_st.fmt = pop_e.word[DSL_FMT_BIT];
					DSL_SEL_PRESET: nxt_st.preset_code = pop_e.word[DSL_CODE_MSB:0];
					default:      nxt_st.fmt = st_ff.fmt;
				endcase
			end
		end
		if (!st_ff.s2.clear_n) begin
			nxt_st.code = st_ff.preset_code; // [RULE2]
		end
		nxt_st.rb_oe = nxt_st.rb_live && !st_ff.s2.frame_n;
		if (srst || !st_ff.s2.reset_n) begin // [RULE1]
			nxt_st.shreg = '0;
			nxt_st.cnt = '0;
			nxt_st.hold_reg = DSL_CODE_RST;
			nxt_st.code = DSL_CODE_RST;
			nxt_st.preset_code = DSL_PRESET_RST;
			nxt_st.fmt = DSL_FMT_RST;
			nxt_st.rb_sel = '0;
			nxt_st.rb_sh = '0;
			nxt_st.rb_arm = 1'b0;
			nxt_st.rb_live = 1'b0;
			nxt_st.rb_bit = 1'b0;
			nxt_st.rb_oe = 1'b0;
			nxt_st.overrun = 1'b0;
		end
		if (srst) begin
			nxt_st.s1 = DSL_PINS_IDLE;
			nxt_st.s2 = DSL_PINS_IDLE;
			nxt_st.s3 = DSL_PINS_IDLE;
		end
		// Two's complement codes are offset by flipping the top bit. [RULE3]
		nxt_st.level = nxt_st.fmt ? {~nxt_st.code[DSL_CODE_MSB], nxt_st.code[DSL_CODE_MSB-1:0]}
			: nxt_st.code;
	end

	always_ff @(posedge sys_clk) begin
		st_ff <= nxt_st;
	end

	assign serial_readback_out = st_ff.rb_bit;
	assign serial_readback_oe  = st_ff.rb_oe;
	assign dac_code            = st_ff.code;
	assign dac_level           = st_ff.level;
	assign twos_comp_sel       = st_ff.fmt;
	assign frame_overrun       = st_ff.overrun;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	property p_reset_pin;
		!st_ff.s2.reset_n |=> (st_ff.code == DSL_CODE_RST)
			&& (st_ff.preset_code == DSL_PRESET_RST) && !st_ff.fmt && (st_ff.cnt == '0);
	endproperty
	a_reset_pin: assert property (p_reset_pin) else $error("reset pin did not restore state"); // [RULE1]

	property p_clear;
		(!st_ff.s2.clear_n && st_ff.s2.reset_n) |=> (st_ff.code == $past(st_ff.preset_code));
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not load the clear code"); // [RULE2]

	property p_format;
		st_ff.fmt |-> (st_ff.level[DSL_CODE_MSB] != st_ff.code[DSL_CODE_MSB])
			&& (st_ff.level[DSL_CODE_MSB-1:0] == st_ff.code[DSL_CODE_MSB-1:0]);
	endproperty
	a_format: assert property (p_format) else $error("level ignores two's complement"); // [RULE3]

	property p_direct;
		(pop && !pop_e.word[DSL_RD_BIT] && pop_sel == DSL_SEL_CODE && !pop_e.hold)
			|=> (st_ff.code == $past(pop_e.word[DSL_CODE_MSB:0]));
	endproperty
	a_direct: assert property (p_direct) else $error("direct load did not update the code"); // [RULE4]

	property p_held;
		(pop && pop_e.hold && !strobe_fall && st_ff.s2.clear_n && st_ff.s2.reset_n)
			|=> $stable(st_ff.code);
	endproperty
	a_held: assert property (p_held) else $error("held word changed the code"); // [RULE5]

	property p_strobe;
		(strobe_fall && !pop && st_ff.s2.clear_n && st_ff.s2.reset_n)
			|=> (st_ff.code == $past(st_ff.hold_reg));
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe fall did not load the code"); // [RULE5]

	property p_rb_edge;
		$changed(st_ff.rb_bit) |-> $past(sclk_rise) || !$past(st_ff.s2.reset_n);
	endproperty
	a_rb_edge: assert property (p_rb_edge) else $error("readback changed off a rising edge"); // [RULE7]

	property p_shift;
		(!st_ff.s2.frame_n && !frame_start && sclk_fall && st_ff.s2.reset_n)
			|=> (st_ff.shreg == {$past(st_ff.shreg[DSL_WORD_W-2:0]), $past(st_ff.s2.sdi)});
	endproperty
	a_shift: assert property (p_shift) else $error("shift register missed a bit"); // [RULE8]

	property p_idle;
		(st_ff.s2.frame_n && st_ff.s3.frame_n && st_ff.s2.reset_n) |=> $stable(st_ff.shreg);
	endproperty
	a_idle: assert property (p_idle) else $error("shifted while frame was inactive"); // [RULE10]

	property p_frame_act;
		(push_valid && push_ready && !u_fifo.out_valid && !st_ff.shreg[DSL_RD_BIT]
			&& st_ff.shreg[DSL_SEL_HI:DSL_SEL_LO] == DSL_SEL_CODE)
			##1 (st_ff.s2.reset_n && st_ff.s2.clear_n)[*2]
			|-> (st_ff.hold_reg == $past(st_ff.shreg[DSL_CODE_MSB:0], 2));
	endproperty
	a_frame_act: assert property (p_frame_act) else $error("word did not act at frame end"); // [RULE11]

	property p_short_frame;
		(frame_end && st_ff.cnt != DSL_CNT_FULL && st_ff.s2.reset_n) |=> $stable(u_fifo.st_ff.wp);
	endproperty
	a_short_frame: assert property (p_short_frame) else $error("partial word was queued"); // [RULE13]

	c_direct:   cover property (pop && !pop_e.hold && pop_sel == DSL_SEL_CODE);
	c_held:     cover property (strobe_fall && st_ff.hold_reg != st_ff.code);
	c_clear:    cover property (!st_ff.s2.clear_n && st_ff.s3.clear_n);
	c_readback: cover property (st_ff.rb_oe && sclk_rise);
endmodule

// ### dsl_host_model.sv
// Behavioural serial host that frames words into the load control and samples readback.
module dsl_host_model (
	output logic      sclk,
	output logic      frame_sel_n,
	output logic      serial_write_in,
	input  wire logic serial_readback_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk = 1'h0;
		frame_sel_n = 1'h1;
		serial_write_in = 1'h0;
	end
	// Sends n bits MSB first and returns the readback bits taken at each falling edge.
	task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
		r = 24'h000000;
		frame_sel_n = 1'h0;
		#40;
		for (int i = 23; i > 23 - n; i--) begin
			#40 sclk = 1'h1;
			serial_write_in = w[i];
			#40 sclk = 1'h0;
			r[i] = serial_readback_out;
		end
		#40 frame_sel_n = 1'h1;
		// Inverted after the frame so a stale level is never taken for data.
		serial_write_in = ~serial_write_in;
		#200;
	endtask
endmodule

// ### tb_dsl_top.sv
// Self-checking testbench of the serial load control.
module tb_dsl_top
	import dsl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  sys_clk, srst, sclk, frame_sel_n, serial_write_in;
	logic                  load_output_strobe_n, clear_to_preset_n, dev_reset_n;
	logic                  serial_readback_out, serial_readback_oe, twos_comp_sel, frame_overrun;
	logic [DSL_CODE_W-1:0] dac_code, dac_level;
	logic [23:0]           rd;
	logic                  rb_line;
	int                    n_errors = 0;
	int                    cmp_count = 0;
	int                    cycles = 0;

	dsl_top #(.FIFO_DEPTH(DSL_FIFO_DEP)) u_dsl_top (.sys_clk(sys_clk), .srst(srst),
		.sclk(sclk), .frame_sel_n(frame_sel_n), .serial_write_in(serial_write_in),
		.load_output_strobe_n(load_output_strobe_n), .clear_to_preset_n(clear_to_preset_n),
		.dev_reset_n(dev_reset_n), .serial_readback_out(serial_readback_out),
		.serial_readback_oe(serial_readback_oe), .dac_code(dac_code), .dac_level(dac_level),
		.twos_comp_sel(twos_comp_sel), .frame_overrun(frame_overrun));
	// A released readback line floats high, so a stale bit is never taken for data.
	assign rb_line = serial_readback_oe ? serial_readback_out : 1'h1;
	dsl_host_model u_dsl_host_model (.sclk(sclk), .frame_sel_n(frame_sel_n),
		.serial_write_in(serial_write_in), .serial_readback_out(rb_line));

	initial begin
		sys_clk = 1'h0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// The whole run needs about 8100 cycles; the ceiling leaves ample margin.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_code(input logic [15:0] exp);
		for (int i = 0; i < 100 && dac_code !== exp; i++)
			@(negedge sys_clk);
		chk({8'h00, dac_code}, {8'h00, exp});
	endtask

	function automatic logic [23:0] wr(input dsl_sel_t sel, input logic [15:0] d);
		return {1'h0, sel, 4'h0, d};
	endfunction

	task automatic send(input logic [23:0] w);
		u_dsl_host_model.xfer(w, 24, rd);
	endtask

	task automatic pins(input logic strobe_n, input logic clear_n, input logic rst_n);
		@(negedge sys_clk);
		load_output_strobe_n = strobe_n;
		clear_to_preset_n = clear_n;
		dev_reset_n = rst_n;
	endtask

	task automatic idle_chk();
		chk({8'h00, dac_code}, 24'h000000);
		chk({8'h00, dac_level}, 24'h000000);
		chk({22'h0, twos_comp_sel, frame_overrun}, 24'h000000);
	endtask

	task automatic t_direct();
		send(wr(DSL_SEL_CODE, 16'h1234));
		chk(rd, 24'hFFFFFF);
		wait_code(16'h1234);
		chk({8'h00, dac_level}, 24'h001234);
		u_dsl_host_model.xfer(wr(DSL_SEL_CODE, 16'h5555), 23, rd);
		repeat (20) @(negedge sys_clk);
		chk({8'h00, dac_code}, 24'h001234);
		$display("t_direct done");
	endtask

	task automatic t_held();
		pins(1'h1, 1'h1, 1'h1);
		send(wr(DSL_SEL_CODE, 16'hABCD));
		repeat (20) @(negedge sys_clk);
		chk({8'h00, dac_code}, 24'h001234);
		pins(1'h0, 1'h1, 1'h1);
		wait_code(16'hABCD);
		$display("t_held done");
	endtask

	task automatic t_read_fmt();
		send({1'h1, DSL_SEL_NOP, 20'h00000});
		send(wr(DSL_SEL_NOP, 16'h0000));
		chk(rd, 24'h00ABCD);
		chk({23'h0, serial_readback_oe}, 24'h000000);
		send(wr(DSL_SEL_CTRL, 16'h0001));
		repeat (20) @(negedge sys_clk);
		chk({8'h00, dac_level}, 24'h002BCD);
		chk({23'h0, twos_comp_sel}, 24'h000001);
		send({1'h1, DSL_SEL_CTRL, 20'h00000});
		send(wr(DSL_SEL_NOP, 16'h0000));
		chk(rd, 24'h400001);
		send(wr(DSL_SEL_PRESET, 16'h8001));
		send({1'h1, DSL_SEL_PRESET, 20'h00000});
		send(wr(DSL_SEL_NOP, 16'h0000));
		chk(rd, 24'h608001);
		pins(1'h0, 1'h0, 1'h1);
		wait_code(16'h8001);
		chk({8'h00, dac_level}, 24'h000001);
		pins(1'h0, 1'h1, 1'h1);
		$display("t_read_fmt done");
	endtask

	// Clear low stalls the drain, so seventeen words overfill the sixteen-word buffer.
	task automatic t_overrun();
		pins(1'h0, 1'h0, 1'h1);
		for (int i = 0; i < 17; i++)
			send(wr(DSL_SEL_CODE, 16'h0100 + 16'(i)));
		chk({23'h0, frame_overrun}, 24'h000001);
		pins(1'h0, 1'h1, 1'h1);
		wait_code(16'h010F);
		$display("t_overrun done");
	endtask

	task automatic t_devrst();
		pins(1'h0, 1'h1, 1'h0);
		repeat (10) @(negedge sys_clk);
		idle_chk();
		pins(1'h0, 1'h1, 1'h1);
		repeat (10) @(negedge sys_clk);
		send(wr(DSL_SEL_CODE, 16'h0042));
		wait_code(16'h0042);
		$display("t_devrst done");
	endtask

	initial begin
		srst = 1'h1;
		load_output_strobe_n = 1'h0;
		clear_to_preset_n = 1'h1;
		dev_reset_n = 1'h1;
		repeat (8) @(negedge sys_clk);
		srst = 1'h0;
		repeat (4) @(negedge sys_clk);
		idle_chk();
		$display("t_reset done");
		t_direct();
		t_held();
		t_read_fmt();
		t_overrun();
		t_devrst();
		conclude();
	end
endmodule
